// File: core/general_timer_config_counter.sv
// Configuration and counting core of a 16-bit general timer, with the
// read-only capture B result of the sibling timer.
// Assumes clock sources and the gate arrive as pins, and the capture
// value comes from logic on core_clk.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module general_timer_config_counter
    import timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] clock_source_pins,
    input wire logic external_gate_pin,
    input wire logic [15:0] timer1_capture_b,
    output logic [15:0] count_out
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q; // Release pipeline; assertion is immediate.
    logic rst_n; // Released reset used by the whole block.

    // Reset asserts at once and releases after two clock edges.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] src_sync; // Synchronised clock source levels.
    logic gate_sync; // Synchronised gate pin.

    sync2 #(.W(4)) u_src_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(clock_source_pins),
        .sync_out(src_sync)
    );
    sync2 #(.W(1)) u_gate_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(external_gate_pin),
        .sync_out(gate_sync)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] cnt_q; // Live counter.
    logic [15:0] top_q; // Top of the counting range.
    logic [15:0] cfg_q; // Configuration image, reserved bits zero.
    logic dir_down_q; // Current counting direction.
    logic wrap_seen_q; // An end of range was reached since last load.
    logic lvl_q; // Filtered source level.
    logic hist_q; // Previous raw sample, used by the glitch filter.
    logic [PRE_W-1:0] pre_q; // Prescaler count.
    logic [31:0] reg_rdata_q; // Read data, valid one cycle after strobe.

    // Named configuration fields.
    wire pin_gate_select = cfg_q[B_GATE];
    wire count_run = cfg_q[B_RUN];
    wire updown_alternate = cfg_q[B_ALT];
    wire start_direction = cfg_q[B_DOWN];
    wire single_period = cfg_q[B_SHOT];
    wire [3:0] clock_divider_exp = cfg_q[B_DIV_HI:B_DIV_LO];
    wire clock_glitch_filter = cfg_q[B_FILT];
    wire clock_edge_select = cfg_q[B_EDGE];
    wire [1:0] clock_source_select = cfg_q[B_SRC_HI:B_SRC_LO];

    // Address decode.
    wire hit_cnt = reg_addr == A_CNT;
    wire hit_top = reg_addr == A_TOP;
    wire hit_cfg = reg_addr == A_CFG;
    wire hit_capb = reg_addr == A_CAPB;
    wire hit_stat = reg_addr == A_STAT;
    wire wr_cnt = reg_wr && hit_cnt;
    wire wr_cfg = reg_wr && hit_cfg;

    // While running, a configuration write may only touch the run bit;
    // this keeps a careless write from corrupting a live count.
    wire [15:0] run_only = 16'h0001 << B_RUN; // Run bit alone.
    // Every writable field, gate select down to source select.
    wire [15:0] cfg_rw = (16'h0001 << (B_GATE + 1)) - 16'h0001;
    wire [15:0] cfg_wmask = count_run ? run_only : cfg_rw;
    wire [15:0] cfg_new = (cfg_q & ~cfg_wmask) | (reg_wdata[15:0] & cfg_wmask);
    wire run_start = wr_cfg && !count_run && cfg_new[B_RUN];

    // ------------------------------------------------------------
    // Clock source selection, filter and edge
    // ------------------------------------------------------------
    wire src_raw = src_sync[clock_source_select];
    // With the filter on, a level is accepted only after two equal samples.
    wire lvl_d = clock_glitch_filter ? ((src_raw == hist_q) ? src_raw : lvl_q)
                                     : src_raw;
    // Rising edge when the edge bit is clear, falling edge when set.
    wire src_edge = (lvl_d != lvl_q) && (lvl_d == !clock_edge_select);

    // ------------------------------------------------------------
    // Prescaler and gating
    // ------------------------------------------------------------
    wire [3:0] div_exp = (clock_divider_exp > DIV_EXP_MAX) ? DIV_EXP_MAX
                                                          : clock_divider_exp;
    wire [PRE_W-1:0] pre_lim = PRE_W'((1 << div_exp) - 1);
    wire gate_ok = !pin_gate_select || gate_sync;
    wire enabled = count_run && gate_ok;
    wire pre_tick = enabled && src_edge && (pre_q == pre_lim);

    // ------------------------------------------------------------
    // Counter step
    // ------------------------------------------------------------
    wire at_end = dir_down_q ? (cnt_q == 16'h0000) : (cnt_q == top_q);
    wire [15:0] cnt_up = cnt_q + 16'h0001;
    wire [15:0] cnt_dn = cnt_q - 16'h0001;
    // In alternate mode a period ends on the return leg.
    wire period_end = at_end && (!updown_alternate ||
                                 dir_down_q != start_direction);
    wire stop_now = pre_tick && single_period && period_end;

    logic [15:0] cnt_d;
    logic dir_d;
    // Next counter and direction.
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_down_q;
        if (wr_cnt) begin
            cnt_d = reg_wdata[15:0];
            dir_d = start_direction;
        end else if (run_start) begin
            dir_d = cfg_new[B_DOWN];
        end else if (pre_tick) begin
            if (!at_end) begin
                cnt_d = dir_down_q ? cnt_dn : cnt_up;
            end else if (updown_alternate) begin
                // Turn round instead of wrapping.
                dir_d = !dir_down_q;
                if (top_q != 16'h0000) begin
                    cnt_d = dir_down_q ? cnt_up : cnt_dn;
                end
            end else begin
                cnt_d = dir_down_q ? top_q : 16'h0000;
            end
        end
    end

    // Counter, direction and wrap tracking.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= RST_CNT;
            dir_down_q <= 1'b0;
            wrap_seen_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_down_q <= dir_d;
            // A load restarts wrap tracking, so it wins here.
            wrap_seen_q <= !wr_cnt && (wrap_seen_q || (pre_tick && at_end));
        end
    end

    // Source filter and prescaler.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 1'b0;
            hist_q <= 1'b0;
            pre_q <= '0;
        end else begin
            lvl_q <= lvl_d;
            hist_q <= src_raw;
            if (!count_run || pre_tick) begin
                pre_q <= '0;
            end else if (enabled && src_edge) begin
                pre_q <= pre_q + PRE_W'(1);
            end
        end
    end

    // Configuration and threshold; single period mode clears the run bit.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= 16'h0000;
            top_q <= RST_TOP;
        end else begin
            if (wr_cfg) begin
                cfg_q <= cfg_new;
            end else if (stop_now) begin
                cfg_q[B_RUN] <= 1'b0;
            end
            if (reg_wr && hit_top) begin
                top_q <= reg_wdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [15:0] stat_val = 16'({count_run, wrap_seen_q, dir_down_q});
    // Capture B is read only; no write path exists for it.
    wire [15:0] rd_mux = hit_cnt ? cnt_q :
                         hit_top ? top_q :
                         hit_cfg ? cfg_q :
                         hit_capb ? timer1_capture_b :
                         hit_stat ? stat_val : 16'h0000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= reg_rd ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end
    assign reg_rdata = reg_rdata_q;
    assign count_out = cnt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_GATE_BLOCKS: assert property (
        pin_gate_select && !gate_sync && !wr_cnt |=> cnt_q == $past(cnt_q))
        else $error("Counter moved while gate pin low.");
    AST_RUN_HALTS: assert property (
        !count_run && !wr_cnt |=> cnt_q == $past(cnt_q))
        else $error("Counter moved while run bit clear.");
    AST_ALT_TURN: assert property (
        pre_tick && at_end && updown_alternate && !wr_cnt
        |=> dir_down_q != $past(dir_down_q))
        else $error("Alternate mode did not reverse.");
    AST_START_DIR: assert property (
        run_start && !wr_cnt |=> dir_down_q == $past(cfg_new[B_DOWN]))
        else $error("Wrong direction after enabling.");
    AST_ONE_SHOT: assert property (
        stop_now && !wr_cfg |=> !count_run)
        else $error("Single period did not stop.");
    AST_PRESCALE: assert property (
        count_run |-> pre_q <= pre_lim)
        else $error("Prescaler count beyond its limit.");
    AST_CNT_READ: assert property (
        reg_rd && hit_cnt |=> reg_rdata == {16'h0000, $past(cnt_q)})
        else $error("Count read returned wrong value.");
    AST_CNT_LOAD: assert property (
        wr_cnt |=> cnt_q == $past(reg_wdata[15:0]) && !wrap_seen_q)
        else $error("Count write did not load.");
    AST_CAPB_READ: assert property (
        reg_rd && hit_capb |=> reg_rdata[15:0] == $past(timer1_capture_b))
        else $error("Capture B read mismatch.");
    AST_TOP_BOUND: assert property (
        pre_tick && !updown_alternate && !dir_down_q && at_end && !wr_cnt
        |=> cnt_q == 16'h0000)
        else $error("Up count did not wrap at top.");

    COV_WRAP_UP: cover property (pre_tick && at_end && !dir_down_q);
    COV_TURN: cover property (pre_tick && at_end && updown_alternate);
    COV_SHOT: cover property (stop_now);
    COV_GATED: cover property (count_run && pin_gate_select && !gate_sync);
endmodule : general_timer_config_counter

// File: core/timer_pkg.sv
// Package for the general timer: register indices, byte addresses,
// configuration field positions and reset values.
// Assumes a 32-bit register port whose byte address is four times the index.
package timer_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam logic [15:0] IDX_CAPB = 16'h4504; // Capture B result of timer 1.
    localparam logic [15:0] IDX_CNT = 16'h4580; // Live counter of timer 2.
    localparam logic [15:0] IDX_TOP = 16'h4586; // Threshold of timer 2.
    localparam logic [15:0] IDX_CFG = 16'h458c; // Configuration of timer 2.
    localparam logic [15:0] IDX_STAT = 16'h45a0; // Status of timer 2.
    localparam logic [ADDR_W-1:0] A_CAPB = {IDX_CAPB, 1'b0} << 1;
    localparam logic [ADDR_W-1:0] A_CNT = {IDX_CNT, 1'b0} << 1;
    localparam logic [ADDR_W-1:0] A_TOP = {IDX_TOP, 1'b0} << 1;
    localparam logic [ADDR_W-1:0] A_CFG = {IDX_CFG, 1'b0} << 1;
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STAT, 1'b0} << 1;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int B_GATE = 12;
    localparam int B_RUN = 11;
    localparam int B_ALT = 10;
    localparam int B_DOWN = 9;
    localparam int B_SHOT = 8;
    localparam int B_DIV_HI = 7;
    localparam int B_DIV_LO = 4;
    localparam int B_FILT = 3;
    localparam int B_EDGE = 2;
    localparam int B_SRC_HI = 1;
    localparam int B_SRC_LO = 0;
    localparam int B_ST_DOWN = 0; // Status: counting downward now.
    localparam int B_ST_WRAP = 1; // Status: an end of range was reached.
    localparam int B_ST_RUN = 2; // Status: counting enabled.

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_TOP = 16'hffff;
    localparam logic [3:0] DIV_EXP_MAX = 4'ha;
    localparam int PRE_W = 10;
endpackage : timer_pkg

// File: core/sync2.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are quasi-static relative to core_clk.
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // First stage, read only by the second stage.
    logic [W-1:0] meta_q;

    // Both stages clear under reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync2

// File: dv/general_timer_config_counter_tb_top.sv
// Self-checking bench for the general timer configuration and counter core.
// Assumes the register map and field positions of timer_pkg; clock sources
// 0 and 1 are toggled by the bench.
`timescale 1ns/10ps
module general_timer_config_counter_tb_top;
    import timer_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0; // Core clock, 5 ns period.
    logic resetn = 1'b0; // Active-low reset, held at start.
    logic [ADDR_W-1:0] reg_addr = '0; // Register byte address.
    logic [31:0] reg_wdata = '0; // Register write data.
    logic reg_wr = 1'b0; // Write strobe.
    logic reg_rd = 1'b0; // Read strobe.
    logic [31:0] reg_rdata; // Registered read data.
    logic [3:0] clock_source_pins = 4'h0; // Counting sources.
    logic external_gate_pin = 1'b0; // Gate pin level.
    logic [15:0] timer1_capture_b = 16'h5a3c; // Capture B from timer 1.
    logic [15:0] count_out; // Live counter.
    int miscompares = 0; // Mismatches seen.
    int cmp_count = 0; // Comparisons made.
    logic [31:0] rv; // Last read value.
    logic [3:0] src_mask = 4'h1; // Source pins that the pulses task drives.

    // Configuration words built from the package field positions.
    localparam logic [31:0] C_RUN = 32'h1 << B_RUN;
    localparam logic [31:0] C_GATE = 32'h1 << B_GATE;
    localparam logic [31:0] C_ALT = 32'h1 << B_ALT;
    localparam logic [31:0] C_DOWN = 32'h1 << B_DOWN;
    localparam logic [31:0] C_SHOT = 32'h1 << B_SHOT;
    localparam logic [31:0] C_DIV2 = 32'h2 << B_DIV_LO;
    localparam logic [31:0] C_FILT = 32'h1 << B_FILT;
    localparam logic [31:0] C_EDGE = 32'h1 << B_EDGE;
    localparam logic [31:0] C_SRC1 = 32'h1 << B_SRC_LO;

    general_timer_config_counter DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .clock_source_pins(clock_source_pins),
        .external_gate_pin(external_gate_pin),
        .timer1_capture_b(timer1_capture_b),
        .count_out(count_out)
    );

    // ------------------------------------------------------------
    // Clock and bus tasks
    // ------------------------------------------------------------
    // Free-running core clock.
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // One-cycle write; the strobe drops at the edge that takes it.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read; data stand only in the cycle after the taking edge,
    // so they are taken at the edge that closes that cycle.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd

    // Compares a value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Reads a register and compares it with the expected word.
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        rd(a, rv);
        chk(rv, e);
    endtask : rd_chk

    // Rising edges on the pins set in src_mask; wide pulses so the filter never matters,
    // then enough settling for the synchroniser and the counter step.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge core_clk);
            clock_source_pins <= src_mask;
            repeat (4) @(posedge core_clk);
            clock_source_pins <= 4'h0;
            repeat (4) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask : pulses

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // The tests need well under a thousand cycles; this limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Reset values, unmapped address and the read-only capture word.
        rd_chk(A_CNT, 32'h0);
        rd_chk(A_TOP, 32'hffff);
        rd_chk(A_CFG, 32'h0);
        rd_chk(A_CAPB, {16'h0, timer1_capture_b});
        wr(A_CAPB, 32'h1111);
        rd_chk(A_CAPB, 32'h5a3c);
        rd_chk('0, 32'h0);
        $display("test reset_values done");
        // Prescaler first, while its phase is still the reset one.
        wr(A_CFG, C_RUN | C_DIV2);
        pulses(8);
        rd_chk(A_CNT, 32'h2);
        chk({16'h0, count_out}, 32'h2);
        wr(A_CFG, 32'h0);
        pulses(3);
        rd_chk(A_CNT, 32'h2);
        wr(A_CNT, 32'h1234);
        rd_chk(A_CNT, 32'h1234);
        $display("test prescale_stop_load done");
        // Up counting with a small top wraps back to zero.
        wr(A_TOP, 32'h5);
        rd_chk(A_TOP, 32'h5);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_RUN);
        pulses(7);
        rd_chk(A_CNT, 32'h1);
        rd_chk(A_CNT, 32'h1);
        // A field change while running keeps only the run bit.
        wr(A_CFG, C_RUN | C_DOWN);
        rd_chk(A_CFG, C_RUN);
        $display("test up_wrap done");
        // Gate pin honoured only when gate select is set.
        wr(A_CFG, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_GATE | C_RUN);
        pulses(2);
        rd_chk(A_CNT, 32'h0);
        external_gate_pin <= 1'b1;
        pulses(2);
        rd_chk(A_CNT, 32'h2);
        external_gate_pin <= 1'b0;
        wr(A_CFG, 32'h0);
        wr(A_CFG, C_RUN);
        pulses(1);
        rd_chk(A_CNT, 32'h3);
        $display("test gate done");
        // Down start from zero reloads the top.
        wr(A_CFG, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_RUN | C_DOWN);
        pulses(1);
        rd_chk(A_CNT, 32'h5);
        // Alternate mode turns round at top: 1,2,3,4,5,4,3.
        wr(A_CFG, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_RUN | C_ALT);
        pulses(7);
        rd_chk(A_CNT, 32'h3);
        $display("test down_alternate done");
        // Single period wraps to zero, stops, and clears the run bit.
        wr(A_CFG, 32'h0);
        wr(A_TOP, 32'h3);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_RUN | C_SHOT);
        pulses(6);
        rd_chk(A_CFG, C_SHOT);
        rd_chk(A_CNT, 32'h0);
        pulses(2);
        rd_chk(A_CNT, 32'h0);
        // A load while running takes effect at once.
        wr(A_CFG, C_RUN);
        wr(A_CNT, 32'h2);
        rd_chk(A_CNT, 32'h2);
        pulses(1);
        rd_chk(A_CNT, 32'h3);
        $display("test single_period done");
        // Falling edges of source 1 through the filter; a one-cycle glitch
        // is dropped and source 0 is no longer heard.
        wr(A_CFG, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_CFG, C_RUN | C_FILT | C_EDGE | C_SRC1);
        src_mask = 4'h2;
        pulses(3);
        rd_chk(A_CNT, 32'h3);
        clock_source_pins <= 4'h2;
        @(posedge core_clk);
        clock_source_pins <= 4'h0;
        repeat (8) @(posedge core_clk);
        src_mask = 4'h1;
        pulses(1);
        rd_chk(A_CNT, 32'h3);
        $display("test source_filter done");
        // A reset in mid-run brings back the reset values.
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd_chk(A_CNT, 32'h0);
        rd_chk(A_TOP, 32'hffff);
        rd_chk(A_CFG, 32'h0);
        $display("test mid_reset done");
        wrap_up();
    end
endmodule : general_timer_config_counter_tb_top
